// ### hw/psfb_flag_bank.sv
// status flag bank: six latched status bytes with clear and force views, gate
// views on all but the misc group, alert line drive and summary bits
// assumes a command decoder on core_clk presents single-cycle register
// accesses, and event inputs from same-clock logic are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none

module psfb_flag_bank
	import psfb_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// register access from the command decoder
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output var  logic [7:0]  reg_rdata,
	output var  logic        reg_rvalid,
	output var  logic        reg_hit,
	// comparison pulses from the converter logic
	input  wire logic        output_high_warning,
	input  wire logic        output_low_warning,
	input  wire logic        load_current_over,
	input  wire logic        fault_timer_expired,
	input  wire logic        load_current_warning,
	input  wire logic        supply_high_warning,
	input  wire logic        supply_low_warning,
	input  wire logic        input_power_warning,
	input  wire logic        hot_trip,
	input  wire logic        hot_warning,
	input  wire logic        cold_warning,
	// protocol checker pulses
	input  wire logic        bad_command,
	input  wire logic        bad_data,
	input  wire logic        packet_check_error,
	input  wire logic        comm_layer_misc,
	// comparator pins, asynchronous
	input  wire logic        input_high_limit_pin,
	input  wire logic        input_low_limit_pin,
	// shared open-drain alert line
	input  wire logic        alert_n_in,
	output var  logic        alert_n_out,
	output var  logic        alert_n_oe,
	// summary bits
	output var  logic        output_voltage_any,
	output var  logic        load_current_trip_copy
);

	////////////////////////////////////////////////////////////////////////
	// storage
	logic [7:0] flags_r [PSFB_NREG];   // latched status flags
	logic [7:0] gate_r  [PSFB_NREG];   // alert gate, 1 = masked
	logic [7:0] flags_nxt [PSFB_NREG]; // next flag values
	logic [7:0] evt [PSFB_NREG];       // hardware set sources
	logic [2:0] pin_raw;               // asynchronous pins
	logic [2:0] sync1_r;               // first synchroniser stage
	logic [2:0] sync2_r;               // second stage
	logic [2:0] sync3_r;               // third stage
	logic [2:0] pin_lvl_r;             // filtered pin levels
	logic [2:0] pin_lvl_nxt;           // next filtered levels
	logic       alert_nxt;             // any unmasked flag
	logic       first_alert;           // we start pulling a free line
	logic [7:0] rdata_nxt;             // read mux result
	logic       hit_nxt;               // address maps to a register

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers, a change counts once stages two and three agree
	assign pin_raw = {alert_n_in, input_low_limit_pin, input_high_limit_pin};

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			// alert line idles released, so no false edge after reset
			sync1_r   <= 3'h4;
			sync2_r   <= 3'h4;
			sync3_r   <= 3'h4;
			pin_lvl_r <= 3'h4;
		end
		else
		begin
			sync1_r   <= pin_raw;
			sync2_r   <= sync1_r;
			sync3_r   <= sync2_r;
			pin_lvl_r <= pin_lvl_nxt;
		end
	end

	genvar p;
	generate
		for (p = 0; p < 3; p++)
		begin : g_pin
			// agreement filter per pin
			assign pin_lvl_nxt[p] = (sync2_r[p] == sync3_r[p]) ?
				sync2_r[p] : pin_lvl_r[p];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// hardware set sources per group
	// first alert: we begin driving while the line was still high
	assign first_alert = alert_nxt && !alert_n_oe &&
		pin_lvl_r[2];

	always_comb
	begin
		for (int i = 0; i < PSFB_NREG; i++)
			evt[i] = 8'h00;
		evt[PSFB_VOUT][PSFB_B_OUT_HIGH] = output_high_warning;
		evt[PSFB_VOUT][PSFB_B_OUT_LOW]  = output_low_warning;
		// trip only once the timer runs out during overcurrent
		evt[PSFB_IOUT][PSFB_B_LOAD_TRIP] =
			load_current_over && fault_timer_expired;
		evt[PSFB_IOUT][PSFB_B_LOAD_WARN] = load_current_warning;
		evt[PSFB_VIN][PSFB_B_SUP_HTRIP]  = pin_lvl_r[0];
		evt[PSFB_VIN][PSFB_B_SUP_HWARN]  = supply_high_warning;
		evt[PSFB_VIN][PSFB_B_SUP_LWARN]  = supply_low_warning;
		evt[PSFB_VIN][PSFB_B_SUP_LTRIP]  = pin_lvl_r[1];
		evt[PSFB_VIN][PSFB_B_PWR_WARN]   = input_power_warning;
		evt[PSFB_TEMP][PSFB_B_HOT_TRIP]  = hot_trip;
		evt[PSFB_TEMP][PSFB_B_HOT_WARN]  = hot_warning;
		evt[PSFB_TEMP][PSFB_B_COLD_WARN] = cold_warning;
		evt[PSFB_COMM][PSFB_B_BAD_CMD]   = bad_command;
		evt[PSFB_COMM][PSFB_B_BAD_DATA]  = bad_data;
		evt[PSFB_COMM][PSFB_B_PKT_ERR]   = packet_check_error;
		evt[PSFB_COMM][PSFB_B_COMM_MISC] = comm_layer_misc;
		evt[PSFB_MISC][PSFB_B_FIRST_ALRT] = first_alert;
	end

	////////////////////////////////////////////////////////////////////////
	// per group flag and gate registers
	genvar g;
	generate
		for (g = 0; g < PSFB_NREG; g++)
		begin : g_grp
			logic clr_hit; // write to the clear view
			logic set_hit; // write to the force alias
			logic gate_hit; // write to the gate
			assign clr_hit  = reg_wr && (reg_addr == PSFB_STAT_ADDR[g]);
			assign set_hit  = reg_wr && (reg_addr == PSFB_FORCE_ADDR[g]);
			assign gate_hit = reg_wr && PSFB_HAS_GATE[g] &&
				(reg_addr == PSFB_GATE_ADDR[g]);

			// set wins over clear; reserved bits never store
			assign flags_nxt[g] = PSFB_IMPL[g] &
				((flags_r[g] & ~(clr_hit ? reg_wdata : 8'h00)) |
				(set_hit ? reg_wdata : 8'h00) | evt[g]);

			// flag state
			always_ff @(posedge core_clk or negedge arst_n)
			begin
				if (!arst_n)
					flags_r[g] <= PSFB_FLAG_RST;
				else
					flags_r[g] <= flags_nxt[g];
			end

			// gate state, implemented bits only
			always_ff @(posedge core_clk or negedge arst_n)
			begin
				if (!arst_n)
					gate_r[g] <= PSFB_GATE_RST &
						(PSFB_HAS_GATE[g] ? PSFB_IMPL[g] : 8'h00);
				else if (gate_hit)
					gate_r[g] <= reg_wdata & PSFB_IMPL[g];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// alert: unmasked flags; groups without a gate count as masked
	always_comb
	begin
		alert_nxt = 1'b0;
		for (int i = 0; i < PSFB_NREG; i++)
			if (PSFB_HAS_GATE[i])
				alert_nxt = alert_nxt |
					(|(flags_r[i] & ~gate_r[i]));
	end

	// alert driver, line pulled low while enabled
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			alert_n_oe  <= 1'b0;
			alert_n_out <= 1'b0;
		end
		else
		begin
			alert_n_oe  <= alert_nxt;
			alert_n_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// summary bits
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			output_voltage_any     <= 1'b0;
			load_current_trip_copy <= 1'b0;
		end
		else
		begin
			output_voltage_any     <= |flags_r[PSFB_VOUT];
			load_current_trip_copy <=
				flags_r[PSFB_IOUT][PSFB_B_LOAD_TRIP];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux, unmapped codes return zero with reg_hit low
	always_comb
	begin
		rdata_nxt = 8'h00;
		hit_nxt   = 1'b0;
		for (int i = 0; i < PSFB_NREG; i++)
		begin
			// clear view and force alias both read the flags
			if (reg_addr == PSFB_STAT_ADDR[i] ||
				reg_addr == PSFB_FORCE_ADDR[i])
			begin
				rdata_nxt = flags_r[i];
				hit_nxt   = 1'b1;
			end
			else if (PSFB_HAS_GATE[i] && reg_addr == PSFB_GATE_ADDR[i])
			begin
				rdata_nxt = gate_r[i];
				hit_nxt   = 1'b1;
			end
		end
	end

	// read answer one cycle after the request
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
			reg_hit    <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_rd;
			reg_hit    <= reg_rd && hit_nxt;
			reg_rdata  <= reg_rd ? rdata_nxt : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	chk_out_high_set: assert property (
		output_high_warning |=> flags_r[PSFB_VOUT][PSFB_B_OUT_HIGH])
		else $error("vout high warning not latched");

	chk_load_trip_set: assert property (
		(load_current_over && fault_timer_expired) |=> ##1 load_current_trip_copy)
		else $error("load trip not copied to summary");

	chk_set_beats_clear: assert property (
		(reg_wr && reg_addr == PSFB_STAT_ADDR[PSFB_COMM] &&
		reg_wdata[PSFB_B_BAD_CMD] && bad_command)
		|=> flags_r[PSFB_COMM][PSFB_B_BAD_CMD])
		else $error("event lost against clear");

	chk_clear_works: assert property (
		(reg_wr && reg_addr == PSFB_STAT_ADDR[PSFB_TEMP] &&
		reg_wdata[PSFB_B_HOT_WARN] && !hot_warning)
		|=> !flags_r[PSFB_TEMP][PSFB_B_HOT_WARN])
		else $error("write one did not clear");

	chk_force_works: assert property (
		(reg_wr && reg_addr == PSFB_FORCE_ADDR[PSFB_VIN] &&
		reg_wdata[PSFB_B_PWR_WARN])
		|=> flags_r[PSFB_VIN][PSFB_B_PWR_WARN])
		else $error("force alias did not set");

	chk_reserved_zero: assert property (
		reg_rvalid |-> ((reg_rdata & ~PSFB_IMPL[PSFB_IOUT]) == 8'h00 ||
		!$past(reg_addr == PSFB_STAT_ADDR[PSFB_IOUT])))
		else $error("reserved status bit read nonzero");

	chk_alert_follow: assert property (
		alert_nxt |=> alert_n_oe ##1 (alert_n_oe || !$past(alert_nxt)))
		else $error("alert not driven for unmasked flag");

	chk_alert_release: assert property (
		(!alert_nxt)[*2] |-> !alert_n_oe)
		else $error("alert held without unmasked flag");

	chk_vout_summary: assert property (
		(|flags_r[PSFB_VOUT]) |=> output_voltage_any)
		else $error("summary bit 15 missing");

	chk_pin_trip: assert property (
		$rose(pin_lvl_r[0]) |=> flags_r[PSFB_VIN][PSFB_B_SUP_HTRIP])
		else $error("input high pin trip not latched");

	chk_first_alert: assert property (
		first_alert |=> flags_r[PSFB_MISC][PSFB_B_FIRST_ALRT] && alert_n_oe)
		else $error("first alert flag not set");

	chk_out_low_set: assert property (
		output_low_warning |=> flags_r[PSFB_VOUT][PSFB_B_OUT_LOW])
		else $error("vout low warning not latched");

	chk_load_warn_set: assert property (
		load_current_warning |=> flags_r[PSFB_IOUT][PSFB_B_LOAD_WARN])
		else $error("load current warning not latched");

	chk_low_pin_trip: assert property (
		$rose(pin_lvl_r[1]) |=> flags_r[PSFB_VIN][PSFB_B_SUP_LTRIP])
		else $error("input low pin trip not latched");

	chk_hot_trip_set: assert property (
		hot_trip |=> flags_r[PSFB_TEMP][PSFB_B_HOT_TRIP])
		else $error("hot trip not latched");

	chk_cold_warn_set: assert property (
		cold_warning |=> flags_r[PSFB_TEMP][PSFB_B_COLD_WARN])
		else $error("cold warning not latched");

	chk_packet_err_set: assert property (
		packet_check_error |=> flags_r[PSFB_COMM][PSFB_B_PKT_ERR])
		else $error("packet check error not latched");

	chk_trip_copy: assert property (
		flags_r[PSFB_IOUT][PSFB_B_LOAD_TRIP] |=> load_current_trip_copy)
		else $error("summary trip copy missing");

	chk_gate_reserved: assert property (
		(reg_rd && reg_addr == PSFB_GATE_ADDR[PSFB_COMM])
		|=> ((reg_rdata & ~PSFB_IMPL[PSFB_COMM]) == 8'h00))
		else $error("reserved gate bit read nonzero");

	chk_unmasked_drive: assert property (
		(|(flags_r[PSFB_TEMP] & ~gate_r[PSFB_TEMP])) |=> alert_n_oe)
		else $error("unmasked temperature flag not driving alert");

	cov_alert_raise: cover property ($rose(alert_n_oe));
	cov_clear_read: cover property (reg_wr ##1 reg_rd ##1 reg_rvalid);
	cov_first_alert: cover property (first_alert);
	cov_pin_trip: cover property ($rose(pin_lvl_r[1]));
	cov_trip_copy: cover property ($rose(load_current_trip_copy));

endmodule

`default_nettype wire

// ### hw/psfb_pkg.sv
// status flag bank constants: register codes, field positions, reset values
// assumes the command decoder hands 16-bit command codes to the bank
package psfb_pkg;

	// register groups, one index per status byte
	localparam int PSFB_NREG = 6;
	localparam int PSFB_VOUT = 0;
	localparam int PSFB_IOUT = 1;
	localparam int PSFB_VIN  = 2;
	localparam int PSFB_TEMP = 3;
	localparam int PSFB_COMM = 4;
	localparam int PSFB_MISC = 5;

	// command codes of the clear views
	localparam logic [15:0] PSFB_STAT_ADDR [PSFB_NREG] = '{
		16'h007A, 16'h007B, 16'h007C,
		16'h007D, 16'h007E, 16'h007F};
	// command codes of the force aliases
	localparam logic [15:0] PSFB_FORCE_ADDR [PSFB_NREG] = '{
		16'hFEC2, 16'hFEC3, 16'hFEC4,
		16'hFEC5, 16'hFEC6, 16'hFED7};
	// command codes of the alert gates; the misc group has none
	localparam logic [15:0] PSFB_GATE_ADDR [PSFB_NREG] = '{
		16'hFED2, 16'hFED3, 16'hFED4,
		16'hFED5, 16'hFED6, 16'h0000};
	localparam logic [PSFB_NREG-1:0] PSFB_HAS_GATE = 6'h1F;

	// implemented flag bits per group
	localparam logic [7:0] PSFB_IMPL [PSFB_NREG] = '{
		8'h60, 8'hA0, 8'hF1, 8'hE0, 8'hE2, 8'h01};

	// flag reset value and implemented gate bits reset value
	localparam logic [7:0] PSFB_FLAG_RST = 8'h00;
	localparam logic [7:0] PSFB_GATE_RST = 8'hFF;

	// bit positions
	localparam int PSFB_B_OUT_HIGH   = 6;
	localparam int PSFB_B_OUT_LOW    = 5;
	localparam int PSFB_B_LOAD_TRIP  = 7;
	localparam int PSFB_B_LOAD_WARN  = 5;
	localparam int PSFB_B_SUP_HTRIP  = 7;
	localparam int PSFB_B_SUP_HWARN  = 6;
	localparam int PSFB_B_SUP_LWARN  = 5;
	localparam int PSFB_B_SUP_LTRIP  = 4;
	localparam int PSFB_B_PWR_WARN   = 0;
	localparam int PSFB_B_HOT_TRIP   = 7;
	localparam int PSFB_B_HOT_WARN   = 6;
	localparam int PSFB_B_COLD_WARN  = 5;
	localparam int PSFB_B_BAD_CMD    = 7;
	localparam int PSFB_B_BAD_DATA   = 6;
	localparam int PSFB_B_PKT_ERR    = 5;
	localparam int PSFB_B_COMM_MISC  = 1;
	localparam int PSFB_B_FIRST_ALRT = 0;

endpackage

// ### sim/psfb_alert_peer.sv
// model of the shared open-drain alert wire and of another device on it
// assumes a pull-up: the line is high unless some party pulls it low
`timescale 1ns/1ps
`default_nettype none

module psfb_alert_peer (
	input  wire logic dev_oe,
	input  wire logic dev_out,
	input  wire logic peer_pull,
	output var  logic alert_n
);
	////////////////////////////////////////////////////////////////////
	// wired-and of all pullers, pull-up when none drives
	always_comb
	begin
		alert_n = 1'b1;
		// device pulls while enabled
		if (dev_oe && !dev_out)
			alert_n = 1'b0;
		// other device on the line
		if (peer_pull)
			alert_n = 1'b0;
	end
endmodule

`default_nettype wire

// ### sim/testbench.sv
// bench for the status flag bank: register tasks, event table, alert
// assumes the peer model resolves the alert wire; inputs move at negedge
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import psfb_pkg::*;
	logic        core_clk;   // 25 MHz clock
	logic        arst_n;     // async reset
	logic [15:0] reg_addr;   // command code
	logic        reg_wr;     // write strobe
	logic        reg_rd;     // read strobe
	logic [7:0]  reg_wdata;  // write data
	wire  [7:0]  reg_rdata;  // read data
	wire         reg_rvalid; // read answer
	wire         reg_hit;    // mapped read
	logic [16:0] ev;         // event and pin stimulus
	logic        peer_pull;  // other device pulls alert
	wire         alert_n;    // resolved alert wire
	wire         a_out;      // device alert level
	wire         a_oe;       // device alert enable
	wire         v_any;      // summary vout bit
	wire         trip_cp;    // summary trip copy
	int          err_total;  // mismatches
	int          tests_run;  // comparisons
	int          g;          // group loop
	logic [7:0]  rv;         // last read value
	logic        rh;         // last hit

	////////////////////////////////////////////////////////////////////
	psfb_flag_bank uut (
		.core_clk(core_clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
		.output_high_warning(ev[0]), .output_low_warning(ev[1]),
		.load_current_over(ev[2]), .fault_timer_expired(ev[3]),
		.load_current_warning(ev[4]), .supply_high_warning(ev[5]),
		.supply_low_warning(ev[6]), .input_power_warning(ev[7]),
		.hot_trip(ev[8]), .hot_warning(ev[9]), .cold_warning(ev[10]),
		.bad_command(ev[11]), .bad_data(ev[12]),
		.packet_check_error(ev[13]), .comm_layer_misc(ev[14]),
		.input_high_limit_pin(ev[15]), .input_low_limit_pin(ev[16]),
		.alert_n_in(alert_n), .alert_n_out(a_out), .alert_n_oe(a_oe),
		.output_voltage_any(v_any), .load_current_trip_copy(trip_cp)
	);

	psfb_alert_peer peer (
		.dev_oe(a_oe), .dev_out(a_out),
		.peer_pull(peer_pull), .alert_n(alert_n)
	);

	////////////////////////////////////////////////////////////////////
	// clock
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic complete_run();
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// one comparison
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(negedge core_clk);
		reg_wr    = 1'b0;
	endtask

	// one-cycle read strobe, bounded wait for the answer
	task automatic rd(input logic [15:0] a);
		int i;
		@(negedge core_clk);
		reg_addr = a;
		reg_rd   = 1'b1;
		@(negedge core_clk);
		reg_rd   = 1'b0;
		for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++)
			@(negedge core_clk);
		rv = reg_rdata;
		rh = reg_hit;
		if (reg_rvalid !== 1'b1)
		begin
			err_total++;
			complete_run();
		end
	endtask

	// mapped read with expected value
	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		rd(a);
		chk($sformatf("reg %h", a), rv, e);
		chk($sformatf("hit %h", a), {7'h0, rh}, 8'h01);
	endtask

	// hold a stimulus, drop it, read flags, clear, read again
	task automatic ev_case(input logic [16:0] m, input int gi,
		input logic [7:0] e);
		@(negedge core_clk);
		ev = m;
		repeat (6) @(negedge core_clk);
		ev = '0;
		repeat (6) @(negedge core_clk);
		rdc(PSFB_STAT_ADDR[gi], e);
		wr(PSFB_STAT_ADDR[gi], 8'hFF);
		rdc(PSFB_STAT_ADDR[gi], 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		err_total = 0;
		tests_run = 0;
		arst_n    = 1'b0;
		reg_addr  = '0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_wdata = '0;
		ev        = '0;
		peer_pull = 1'b0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		arst_n = 1'b1;
		// reset values, reserved gate bits, force alias
		for (g = 0; g < PSFB_NREG; g++)
		begin
			rdc(PSFB_STAT_ADDR[g], 8'h00);
			if (PSFB_HAS_GATE[g])
			begin
				rdc(PSFB_GATE_ADDR[g], PSFB_IMPL[g]);
				wr(PSFB_GATE_ADDR[g], 8'hFF);
				rdc(PSFB_GATE_ADDR[g], PSFB_IMPL[g]);
			end
			wr(PSFB_FORCE_ADDR[g], 8'hFF);
			rdc(PSFB_STAT_ADDR[g], PSFB_IMPL[g]);
		end
		// summaries follow forced flags, all gated off
		chk("vout_any", {7'h0, v_any}, 8'h01);
		chk("trip_copy", {7'h0, trip_cp}, 8'h01);
		chk("alert_oe", {7'h0, a_oe}, 8'h00);
		// clear of a single bit
		wr(PSFB_STAT_ADDR[PSFB_VOUT], 8'h40);
		rdc(PSFB_STAT_ADDR[PSFB_VOUT], 8'h20);
		for (g = 0; g < PSFB_NREG; g++)
			wr(PSFB_STAT_ADDR[g], 8'hFF);
		repeat (3) @(negedge core_clk);
		chk("vout_any", {7'h0, v_any}, 8'h00);
		chk("trip_copy", {7'h0, trip_cp}, 8'h00);
		// unmapped place
		wr(16'h0080, 8'hFF);
		rd(16'h0080);
		chk("unmapped", rv, 8'h00);
		chk("unmapped hit", {7'h0, rh}, 8'h00);
		// event sources
		ev_case(17'h0_0001, PSFB_VOUT, 8'h40);
		ev_case(17'h0_0002, PSFB_VOUT, 8'h20);
		ev_case(17'h0_0004, PSFB_IOUT, 8'h00);
		ev_case(17'h0_000C, PSFB_IOUT, 8'h80);
		ev_case(17'h0_0010, PSFB_IOUT, 8'h20);
		ev_case(17'h0_8000, PSFB_VIN, 8'h80);
		ev_case(17'h0_0020, PSFB_VIN, 8'h40);
		ev_case(17'h0_0040, PSFB_VIN, 8'h20);
		ev_case(17'h1_0000, PSFB_VIN, 8'h10);
		ev_case(17'h0_0080, PSFB_VIN, 8'h01);
		ev_case(17'h0_0100, PSFB_TEMP, 8'h80);
		ev_case(17'h0_0200, PSFB_TEMP, 8'h40);
		ev_case(17'h0_0400, PSFB_TEMP, 8'h20);
		ev_case(17'h0_0800, PSFB_COMM, 8'h80);
		ev_case(17'h0_1000, PSFB_COMM, 8'h40);
		ev_case(17'h0_2000, PSFB_COMM, 8'h20);
		ev_case(17'h0_4000, PSFB_COMM, 8'h02);
		// unmasked warning pulls the line, first on the bus
		wr(PSFB_GATE_ADDR[PSFB_TEMP], 8'h00);
		@(negedge core_clk);
		ev[9] = 1'b1;
		@(negedge core_clk);
		ev[9] = 1'b0;
		repeat (3) @(negedge core_clk);
		chk("alert", {7'h0, alert_n}, 8'h00);
		rdc(PSFB_STAT_ADDR[PSFB_MISC], 8'h01);
		wr(PSFB_STAT_ADDR[PSFB_TEMP], 8'hFF);
		repeat (2) @(negedge core_clk);
		chk("alert", {7'h0, alert_n}, 8'h01);
		wr(PSFB_STAT_ADDR[PSFB_MISC], 8'hFF);
		// another device already holds the line low
		peer_pull = 1'b1;
		repeat (4) @(negedge core_clk);
		wr(PSFB_FORCE_ADDR[PSFB_TEMP], 8'h20);
		repeat (3) @(negedge core_clk);
		chk("alert_oe", {7'h0, a_oe}, 8'h01);
		rdc(PSFB_STAT_ADDR[PSFB_MISC], 8'h00);
		// masking the flag releases the line
		wr(PSFB_GATE_ADDR[PSFB_TEMP], 8'hFF);
		repeat (2) @(negedge core_clk);
		chk("alert_oe", {7'h0, a_oe}, 8'h00);
		peer_pull = 1'b0;
		complete_run();
	end
endmodule

`default_nettype wire
